/* File: remote_status_line_relay.sv */
// Purpose: remote control application layer relaying eight status lines
// Assumes: packet radio link logic on pclk; pins asynchronous to pclk
// Notes: registers over APB, no wait state on any transfer
// Notes on behaviour
// - eight lines, input high mirrors remote output
// - all inputs: initiator only, sleep until rise
// - all outputs: responder only, always receiving
// - mixed: idle receiving, wake on rx or rise
// - input rise samples lines into activation packet
// - repeat every 140 ms while inputs high
// - listen for confirmation after each activation
// - confirmation carries ack time, stay flag
// - hold ack high, then resample and resend
// - inputs all low: two all-low packets
// - all inputs: sleep 760 ms after finals
// - activation makes responder until 760 ms quiet
// - momentary outputs follow latest packet bits
// - latched outputs toggle on 0 to 1
// - ack request high: send 20 ms confirmation, stay flag clear
// - raise ack indicator on received confirmation
// - responder refreshes outputs every packet
// - broadcast destination unless software overrides
//
// Implementation choices: the APB register port and the placing of the registers.
module remote_status_line_relay #(
    parameter int unsigned TICK_CYCLES = relay_pkg::MS_CYCLES
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire relay_pkg::apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status line pins
    input wire logic [7:0] status_lines_in,
    output logic [7:0] status_lines_out,
    output logic [7:0] status_lines_oe,
    // configuration pins
    input wire logic direction_select_low_group,
    input wire logic direction_select_high_group,
    input wire logic latch_select,
    input wire logic ack_request,
    // indicator pins
    output logic ack_indicator,
    output logic low_power,
    // packet radio link
    output relay_pkg::packet_s tx_pkt,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire relay_pkg::packet_s rx_pkt,
    input wire logic rx_valid
);
    import relay_pkg::*;

    // saturating increment of a ms counter
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    // prescaler step, high on the wrap cycle
    function automatic logic presc_wrap(input logic [31:0] c);
        return c >= 32'(TICK_CYCLES - 1);
    endfunction

    logic [7:0] sync1_ff, sync2_ff, prev_in_ff;
    logic [2:0] cfg1_ff, cfg2_ff;
    logic ack_req1_ff, ack_req2_ff;
    relay_state_e state_ff, nxt_state;
    logic [31:0] presc_ff, ru_presc_ff;
    logic [15:0] ms_ff, ru_ms_ff, ack_len_ff;
    logic [1:0] final_cnt_ff, nxt_final_cnt;
    logic stay_ff, cfm_pend_ff, ru_active_ff;
    logic [7:0] out_lines_ff, prev_rx_ff, dest_ff;
    logic inhibit_ff;
    logic [7:0] in_mask, in_lines, rises;
    logic all_inputs, any_high, timer_restart, load_act, load_final, load_cfm;
    logic rx_act, rx_cfm, ru_accept, wr_en, rd_setup;

    // two-flop synchronisers for every pin input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
            cfg1_ff <= 3'h3; // start as all inputs so no line is driven early
            cfg2_ff <= 3'h3;
            ack_req1_ff <= 1'b0;
            ack_req2_ff <= 1'b0;
        end else if (clk_en) begin
            sync1_ff <= status_lines_in;
            sync2_ff <= sync1_ff;
            cfg1_ff <= {latch_select, direction_select_high_group, direction_select_low_group};
            cfg2_ff <= cfg1_ff;
            ack_req1_ff <= ack_request;
            ack_req2_ff <= ack_req1_ff;
        end
    end

    // direction groups, rising edges and sampled levels
    assign in_mask = {{4{cfg2_ff[1]}}, {4{cfg2_ff[0]}}};
    assign in_lines = sync2_ff & in_mask;
    assign rises = in_lines & ~prev_in_ff;
    assign all_inputs = &cfg2_ff[1:0];
    assign any_high = |in_lines;
    assign rx_act = rx_valid && (rx_pkt.kind == PKT_ACTIVATE);
    assign rx_cfm = rx_valid && (rx_pkt.kind == PKT_CONFIRM);
    // receiving is open whenever not in the initiator exchange or asleep
    assign ru_accept = rx_act && (state_ff == ST_IDLE || state_ff == ST_LINGER
                                  || state_ff == ST_CONFIRM);

    // previous input levels for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_in_ff <= 8'h00;
        end else if (clk_en) begin
            prev_in_ff <= in_lines;
        end
    end

    // initiator and sleep sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_final_cnt = final_cnt_ff;
        timer_restart = 1'b0;
        load_act = 1'b0;
        load_final = 1'b0;
        load_cfm = 1'b0;
        case (state_ff)
            ST_SLEEP: begin
                if (|rises) begin
                    nxt_state = ST_SEND;
                    load_act = 1'b1;
                end else if (!all_inputs || inhibit_ff) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cfm_pend_ff) begin
                    nxt_state = ST_CONFIRM;
                    load_cfm = 1'b1;
                end else if (|rises) begin
                    nxt_state = ST_SEND;
                    load_act = 1'b1;
                end else if (all_inputs && !inhibit_ff && !stay_ff) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SEND: begin
                if (tx_ready) begin
                    timer_restart = 1'b1;
                    if (final_cnt_ff == 2'h0) begin
                        nxt_state = ST_LISTEN;
                    end else if (final_cnt_ff == 2'h1) begin
                        nxt_final_cnt = 2'h0;
                        nxt_state = all_inputs ? ST_LINGER : ST_IDLE;
                    end else begin
                        nxt_final_cnt = final_cnt_ff - 2'h1;
                    end
                end
            end
            ST_LISTEN: begin
                if (rx_cfm) begin
                    nxt_state = ST_ACK;
                    timer_restart = 1'b1;
                end else if (ms_ff >= REPEAT_MS) begin
                    nxt_state = ST_SEND;
                    load_act = any_high;
                    load_final = !any_high;
                    nxt_final_cnt = any_high ? 2'h0 : FINAL_PACKETS;
                end
            end
            ST_ACK: begin
                if (ms_ff >= ack_len_ff) begin
                    nxt_state = ST_SEND;
                    load_act = any_high;
                    load_final = !any_high;
                    nxt_final_cnt = any_high ? 2'h0 : FINAL_PACKETS;
                end
            end
            ST_LINGER: begin
                if (cfm_pend_ff) begin
                    nxt_state = ST_CONFIRM;
                    load_cfm = 1'b1;
                end else if (|rises) begin
                    nxt_state = ST_SEND;
                    load_act = 1'b1;
                end else if (ms_ff >= SLEEP_DELAY_MS) begin
                    nxt_state = (stay_ff || inhibit_ff) ? ST_IDLE : ST_SLEEP;
                end
            end
            ST_CONFIRM: begin
                if (tx_ready) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state register and final packet counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            final_cnt_ff <= 2'h0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            final_cnt_ff <= nxt_final_cnt;
        end
    end

    // ms timer for repeat, ack hold and sleep delay, restarted per phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_ff <= 32'h0000_0000;
            ms_ff <= 16'h0000;
        end else if (clk_en) begin
            if (timer_restart) begin
                presc_ff <= 32'h0000_0000;
                ms_ff <= 16'h0000;
            end else if (presc_wrap(presc_ff)) begin
                presc_ff <= 32'h0000_0000;
                ms_ff <= sat_inc(ms_ff);
            end else begin
                presc_ff <= presc_ff + 32'h0000_0001;
            end
        end
    end

    // values carried by a received confirmation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_len_ff <= ACK_DEFAULT_MS;
            stay_ff <= 1'b0;
        end else if (clk_en) begin
            if (rx_cfm && (state_ff == ST_LISTEN || state_ff == ST_LINGER)) begin
                ack_len_ff <= rx_pkt.ack_ms;
                stay_ff <= rx_pkt.stay_awake;
            end else if (state_ff == ST_SLEEP) begin
                stay_ff <= 1'b0;
            end
        end
    end

    // outgoing packet and its handshake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_pkt <= '0;
            tx_valid <= 1'b0;
        end else if (clk_en) begin
            if (load_act || load_final) begin
                tx_pkt.kind <= PKT_ACTIVATE;
                tx_pkt.dest_id <= dest_ff;
                tx_pkt.lines <= load_act ? in_lines : 8'h00;
                tx_pkt.ack_ms <= 16'h0000;
                tx_pkt.stay_awake <= 1'b0;
                tx_valid <= 1'b1;
            end else if (load_cfm) begin
                tx_pkt.kind <= PKT_CONFIRM;
                tx_pkt.dest_id <= dest_ff;
                tx_pkt.lines <= 8'h00;
                tx_pkt.ack_ms <= ACK_DEFAULT_MS;
                tx_pkt.stay_awake <= 1'b0;
                tx_valid <= 1'b1;
            end else if (tx_ready && nxt_state != ST_SEND) begin
                tx_valid <= 1'b0;
            end
        end
    end

    // responder role timeout and pending confirmation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ru_active_ff <= 1'b0;
            ru_presc_ff <= 32'h0000_0000;
            ru_ms_ff <= 16'h0000;
            cfm_pend_ff <= 1'b0;
        end else if (clk_en) begin
            if (ru_accept) begin
                ru_active_ff <= 1'b1;
                ru_presc_ff <= 32'h0000_0000;
                ru_ms_ff <= 16'h0000;
            end else if (ru_active_ff) begin
                if (ru_ms_ff >= SLEEP_DELAY_MS) begin
                    ru_active_ff <= 1'b0;
                end
                if (presc_wrap(ru_presc_ff)) begin
                    ru_presc_ff <= 32'h0000_0000;
                    ru_ms_ff <= sat_inc(ru_ms_ff);
                end else begin
                    ru_presc_ff <= ru_presc_ff + 32'h0000_0001;
                end
            end
            // a new request wins over the clear of the one just sent
            if (ru_accept && ack_req2_ff) begin
                cfm_pend_ff <= 1'b1;
            end else if (state_ff == ST_CONFIRM && tx_ready) begin
                cfm_pend_ff <= 1'b0;
            end
        end
    end

    // output line states from received activations
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_lines_ff <= 8'h00;
            prev_rx_ff <= 8'h00;
        end else if (clk_en) begin
            if (ru_accept) begin
                prev_rx_ff <= rx_pkt.lines;
                if (cfg2_ff[2]) begin
                    out_lines_ff <= out_lines_ff ^ (rx_pkt.lines & ~prev_rx_ff);
                end else begin
                    out_lines_ff <= rx_pkt.lines;
                end
            end else if (ru_active_ff && ru_ms_ff >= SLEEP_DELAY_MS) begin
                prev_rx_ff <= 8'h00;
                if (!cfg2_ff[2]) begin
                    out_lines_ff <= 8'h00; // momentary lines drop with the link
                end
            end
        end
    end

    // pin drivers and indicators, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_lines_out <= 8'h00;
            status_lines_oe <= 8'h00;
            ack_indicator <= 1'b0;
            low_power <= 1'b0;
        end else if (clk_en) begin
            status_lines_out <= out_lines_ff & ~in_mask;
            status_lines_oe <= ~in_mask;
            ack_indicator <= (nxt_state == ST_ACK);
            low_power <= (nxt_state == ST_SLEEP);
        end
    end

    // apb decode: answer is ready in the cycle after setup
    assign rd_setup = apb_req.psel && !apb_req.penable && !pready;
    assign wr_en = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;

    // apb handshake and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            pready <= rd_setup;
            if (rd_setup) begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
                case (apb_req.paddr)
                    CTRL_OFS: prdata[CTRL_INHIBIT_BIT] <= inhibit_ff;
                    DEST_OFS: prdata[7:0] <= dest_ff;
                    STATUS_OFS: begin
                        prdata[2:0] <= state_ff;
                        prdata[ST_RU_BIT] <= ru_active_ff;
                        prdata[ST_CFM_BIT] <= cfm_pend_ff;
                        prdata[ST_STAY_BIT] <= stay_ff;
                    end
                    LINES_OFS: prdata[15:0] <= {in_lines, out_lines_ff};
                    default: pslverr <= 1'b1; // unmapped
                endcase
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // software-written control and destination
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inhibit_ff <= CTRL_RESET[CTRL_INHIBIT_BIT];
            dest_ff <= BROADCAST_ID;
        end else if (clk_en && wr_en) begin
            if (apb_req.paddr == CTRL_OFS) begin
                inhibit_ff <= apb_req.pwdata[CTRL_INHIBIT_BIT];
            end
            if (apb_req.paddr == DEST_OFS) begin
                dest_ff <= apb_req.pwdata[7:0];
            end
        end
    end
endmodule // remote_status_line_relay

/* File: relay_pkg.sv */
// Purpose: shared constants and types for the status line relay
// Assumes: 100 MHz pclk, 32-bit APB register access
// Notes: all times are kept in ms and turned into cycles from the clock rate
package relay_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
    // timing in ms
    localparam logic [15:0] REPEAT_MS = 16'h008C; // 140 ms nominal repeat
    localparam logic [15:0] REPEAT_MAX_MS = 16'h00F0; // 240 ms ceiling
    localparam logic [15:0] ACK_DEFAULT_MS = 16'h0014; // 20 ms
    localparam logic [15:0] SLEEP_DELAY_MS = 16'h02F8; // 760 ms
    // line and packet counts
    localparam int unsigned NUM_LINES = 8;
    localparam logic [1:0] FINAL_PACKETS = 2'h2;
    // register offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] DEST_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] LINES_OFS = 8'h0C;
    // field positions and reset values
    localparam int unsigned CTRL_INHIBIT_BIT = 0;
    localparam int unsigned ST_RU_BIT = 3;
    localparam int unsigned ST_CFM_BIT = 4;
    localparam int unsigned ST_STAY_BIT = 5;
    localparam logic [7:0] BROADCAST_ID = 8'hFF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        PKT_NONE = 2'b00,
        PKT_ACTIVATE = 2'b01,
        PKT_CONFIRM = 2'b10
    } pkt_kind_e;

    typedef struct packed {
        pkt_kind_e kind;
        logic [7:0] dest_id;
        logic [7:0] lines;
        logic [15:0] ack_ms;
        logic stay_awake;
    } packet_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef enum logic [2:0] {
        ST_SLEEP = 3'b000,
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_LISTEN = 3'b011,
        ST_ACK = 3'b100,
        ST_LINGER = 3'b101,
        ST_CONFIRM = 3'b110
    } relay_state_e;
endpackage

/* File: relay_link_model.sv */
// Purpose: packet link partner for the status line relay
// Assumes: shares pclk, may stall acceptance
// Notes: receive data scrambles between packets
module relay_link_model
    import relay_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // relay transmit side
    input wire relay_pkg::packet_s tx_pkt,
    input wire logic tx_valid,
    output logic tx_ready,
    // relay receive side
    output relay_pkg::packet_s rx_pkt,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 32'h16f878d1;
    logic [1:0] stall_ff;
    initial begin
        rx_pkt = '0;
        rx_valid = 1'b0;
    end
    // accept each packet after a random stall of up to three cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ready <= 1'b0;
            stall_ff <= 2'h0;
        end else if (tx_valid && tx_ready) begin
            tx_ready <= 1'b0;
            stall_ff <= 2'($random(seed));
        end else if (tx_valid && stall_ff == 2'h0) begin
            tx_ready <= 1'b1;
        end else if (tx_valid) begin
            stall_ff <= stall_ff - 2'h1;
        end
    end
    // one cycle of valid, then inverted stale data
    task automatic send_rx(input packet_s pkt);
        rx_pkt <= pkt;
        rx_valid <= 1'b1;
        @(posedge pclk);
        rx_pkt <= packet_s'(~pkt);
        rx_valid <= 1'b0;
        @(posedge pclk);
    endtask
endmodule // relay_link_model

/* File: remote_status_line_relay_asserts.sv */
// Purpose: port checks for the status line relay
// Assumes: one pclk domain, presetn async low
// Notes: bound into every relay instance
module relay_asserts
    import relay_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = 10
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire relay_pkg::apb_req_s apb_req,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic [7:0] status_lines_out,
    input wire logic [7:0] status_lines_oe,
    input wire logic direction_select_low_group,
    input wire logic direction_select_high_group,
    input wire logic latch_select,
    input wire logic ack_indicator,
    input wire logic low_power,
    // link
    input wire relay_pkg::packet_s tx_pkt,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire relay_pkg::packet_s rx_pkt,
    input wire logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] up_ff;
    // cycles since reset release, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_ff <= 3'h0;
        else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
    end
    sequence s_setup;
        apb_req.psel && !apb_req.penable && !pready;
    endsequence
    sequence s_dir_steady;
        (up_ff == 3'h7 && $stable({direction_select_high_group, direction_select_low_group}))[*4];
    endsequence
    sequence s_rx_act;
        rx_valid && rx_pkt.kind == PKT_ACTIVATE && status_lines_oe == 8'hFF && !latch_select;
    endsequence
    AST_APB_ANSWER: assert property (s_setup |=> pready)
        else $error("apb setup not answered next cycle");
    AST_APB_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error flag outside answer or with data");
    AST_TX_HOLD: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_pkt))
        else $error("packet changed before acceptance");
    AST_SLEEP_QUIET: assert property (low_power |-> !tx_valid && !ack_indicator)
        else $error("activity while asleep");
    AST_OE_GROUPS: assert property (s_dir_steady |-> status_lines_oe ==
        {{4{!direction_select_high_group}}, {4{!direction_select_low_group}}})
        else $error("line drive does not match direction pins");
    AST_OUT_MASKED: assert property ((status_lines_out & ~status_lines_oe) == 8'h00)
        else $error("level on a line that is not driven");
    AST_MOMENTARY: assert property (
        s_rx_act |-> ##2 status_lines_out == $past(rx_pkt.lines, 2))
        else $error("momentary outputs differ from packet");
    AST_CONFIRM_FIELDS: assert property (
        tx_valid && tx_pkt.kind == PKT_CONFIRM |-> tx_pkt.ack_ms == ACK_DEFAULT_MS
        && !tx_pkt.stay_awake)
        else $error("confirmation carries wrong values");
    AST_ACK_RESEND: assert property ($fell(ack_indicator) |-> ##[0:8] tx_valid)
        else $error("no resend after ack hold");
endmodule // relay_asserts

bind remote_status_line_relay relay_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .pclk, .presetn, .apb_req, .prdata, .pready, .pslverr, .status_lines_out,
    .status_lines_oe, .direction_select_low_group, .direction_select_high_group,
    .latch_select, .ack_indicator, .low_power, .tx_pkt, .tx_valid, .tx_ready,
    .rx_pkt, .rx_valid);

/* File: remote_status_line_relay_bench.sv */
// Purpose: self-checking bench for the status line relay
// Assumes: 10 cycles per ms to keep runs short
// Notes: notes queued by drivers, checked by a monitor
module remote_status_line_relay_bench
    import relay_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned TK = 10;
    logic pclk = 1'b0, presetn = 1'b0, pready, pslverr, tx_valid, tx_ready, rx_valid;
    logic ack_indicator, low_power, latch_select = 1'b0, ack_request = 1'b0;
    logic direction_select_low_group = 1'b1, direction_select_high_group = 1'b1;
    logic [7:0] status_lines_in = 8'h00, status_lines_out, status_lines_oe;
    logic [31:0] prdata;
    logic [2:0] act_d = 3'h0;
    apb_req_s apb = '0;
    packet_s tx_pkt, rx_pkt;
    packet_s q_tx[$];
    logic [32:0] q_apb[$];
    logic [7:0] q_out[$];
    int bad_count = 0, checks = 0, seed = 32'h16f878d1;
    always #5 pclk = ~pclk;
    remote_status_line_relay #(.TICK_CYCLES(TK)) dut_u (.pclk, .presetn, .clk_en(1'b1),
        .apb_req(apb), .prdata, .pready, .pslverr, .status_lines_in, .status_lines_out,
        .status_lines_oe, .direction_select_low_group, .direction_select_high_group,
        .latch_select, .ack_request, .ack_indicator, .low_power, .tx_pkt, .tx_valid,
        .tx_ready, .rx_pkt, .rx_valid);
    relay_link_model link_u (.pclk, .presetn, .tx_pkt, .tx_valid, .tx_ready, .rx_pkt,
        .rx_valid);
    function automatic packet_s mk(pkt_kind_e k, logic [7:0] l, logic [15:0] a);
        return {k, 8'hFF, l, a, 1'b0};
    endfunction
    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pkt(input packet_s got, input packet_s exp);
        if (exp.kind == PKT_CONFIRM) cmp({got.kind, got.ack_ms, got.stay_awake},
            {exp.kind, exp.ack_ms, exp.stay_awake});
        else cmp({got.kind, got.dest_id, got.lines}, {exp.kind, exp.dest_id, exp.lines});
    endtask
    // monitor: each result against the oldest note
    always @(posedge pclk) begin
        if (tx_valid && tx_ready) begin
            if (q_tx.size() == 0) cmp(1, 0);
            else cmp_pkt(tx_pkt, q_tx.pop_front());
        end
        if (apb.psel && apb.penable && pready && q_apb.size() != 0)
            cmp({pslverr, prdata}, q_apb.pop_front());
        if (act_d[2] && q_out.size() != 0)
            cmp(status_lines_out, q_out.pop_front());
        act_d <= {act_d[1:0], rx_valid && rx_pkt.kind == PKT_ACTIVATE};
    end
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [32:0] d);
        if (!wr) q_apb.push_back(d);
        apb <= {1'b1, 1'b0, wr, a, d[31:0]};
        @(posedge pclk);
        apb.penable <= 1'b1;
        // hold the access until the slave answers; only the watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        apb <= '0;
        @(posedge pclk);
    endtask
    task automatic wait_tx(input int k, input int lim, output int n);
        n = 0;
        while (q_tx.size() > k && n < lim) begin
            @(posedge pclk);
            n++;
        end
        if (q_tx.size() > k) cmp(0, 1);
    endtask
    task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (s !== v && n < lim);
    endtask
    task automatic test_done();
        if (bad_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask
    // watchdog
    initial begin
        repeat (30000) @(posedge pclk);
        bad_count++;
        test_done();
    end
    // main sequence: initiator, then responder
    initial begin
        int n;
        logic [7:0] dst, ins;
        logic [7:0] lat_in[4] = '{8'hA3, 8'h5C, 8'h00, 8'h81};
        logic [7:0] lat_ex[4] = '{8'hA3, 8'hFF, 8'hFF, 8'h7E};
        dst = 8'($random(seed));
        ins = 8'($random(seed)) | 8'h01;
        do_reset();
        cmp(low_power, 1);
        apb_xfer(0, DEST_OFS, {25'h0, BROADCAST_ID});
        apb_xfer(1, DEST_OFS, {25'h0, dst});
        apb_xfer(0, DEST_OFS, {25'h0, dst});
        apb_xfer(0, CTRL_OFS, {1'b0, CTRL_RESET});
        apb_xfer(0, 8'h10, 33'h1_0000_0000);
        repeat (2) q_tx.push_back({PKT_ACTIVATE, dst, ins, 17'h0});
        status_lines_in <= ins;
        wait_tx(1, 100, n);
        wait_tx(0, 3000, n);
        cmp(n >= 1300 && n <= 2400, 1);
        repeat (5) @(posedge pclk);
        q_tx.push_back({PKT_ACTIVATE, dst, ins, 17'h0});
        link_u.send_rx(mk(PKT_CONFIRM, 8'h00, 16'h0003));
        wait_for(ack_indicator, 1, 20, n);
        wait_for(ack_indicator, 0, 100, n);
        cmp(n, 3 * TK);
        wait_tx(0, 100, n);
        status_lines_in <= 8'h00;
        repeat (2) q_tx.push_back({PKT_ACTIVATE, dst, 25'h0});
        wait_tx(0, 3000, n);
        wait_for(low_power, 1, 9000, n);
        cmp(n >= 7590 && n <= 7700, 1);
        direction_select_low_group <= 1'b0;
        direction_select_high_group <= 1'b0;
        ack_request <= 1'b1;
        do_reset();
        cmp(low_power, 0);
        q_out.push_back(8'h05);
        q_tx.push_back(mk(PKT_CONFIRM, 8'h00, ACK_DEFAULT_MS));
        link_u.send_rx(mk(PKT_ACTIVATE, 8'h05, 16'h0));
        wait_tx(0, 100, n);
        apb_xfer(0, STATUS_OFS, 33'(ST_IDLE) | (33'h1 << ST_RU_BIT));
        ack_request <= 1'b0;
        repeat (5) @(posedge pclk);
        q_out.push_back(8'hA3);
        link_u.send_rx(mk(PKT_ACTIVATE, 8'hA3, 16'h0));
        apb_xfer(0, LINES_OFS, 33'h0_0000_00A3);
        latch_select <= 1'b1;
        repeat (6) @(posedge pclk);
        foreach (lat_in[i]) begin
            q_out.push_back(lat_ex[i]);
            link_u.send_rx(mk(PKT_ACTIVATE, lat_in[i], 16'h0));
            repeat (4) @(posedge pclk);
        end
        repeat (5) @(posedge pclk);
        cmp(q_out.size() + q_tx.size(), 0);
        test_done();
    end
endmodule // remote_status_line_relay_bench
